// *** hdl/rcc_consts.svh ***
// register offsets, field positions, reset values and timing for the rtc core
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

// register byte offsets
`define RCC_OFS_ELAPSED_COUNT 12'h000
`define RCC_OFS_ALARM_COMPARE 12'h004
`define RCC_OFS_CLOCK_CONTROL 12'h008
`define RCC_OFS_EVENT_STATUS 12'h00c
`define RCC_OFS_IRQ_WAKE_ENABLE 12'h010

// reset values
`define RCC_RST_ELAPSED_COUNT 32'h0000_0000
`define RCC_RST_ALARM_COMPARE 32'h0000_0000
`define RCC_RST_CLOCK_CONTROL 32'h0000_0f04
`define RCC_RST_EVENT_STATUS 32'h0000_0000
`define RCC_RST_IRQ_WAKE_ENABLE 32'h0000_0000

// clock_control fields
`define RCC_CC_RUN_ENABLE 0
`define RCC_CC_SOURCE_SELECT 1
`define RCC_CC_INTERNAL_OSC_EN 2
`define RCC_CC_CRYSTAL_OSC_EN 3
`define RCC_CC_CLEAR_ON_MATCH 4
`define RCC_CC_CRYSTAL_STARTUP 5
`define RCC_CC_PRESCALE_LSB 8
`define RCC_CC_PRESCALE_MSB 11
`define RCC_CC_OUT_PIN_ENABLE 16
`define RCC_CC_OUT_EVENT_SELECT 17
`define RCC_CC_OUT_WAVE_MODE 18
`define RCC_CC_OUT_POLARITY 19
`define RCC_CC_OUT_LEVEL_FLAG 20
// software-writable bits of clock_control (level flag is read-clear only)
`define RCC_CC_WRITE_MASK 32'h000f_0f3f

// event_status and irq_wake_enable fields
`define RCC_ST_SECOND 0
`define RCC_ST_MATCH 1
`define RCC_ST_OVERFLOW 2
`define RCC_IE_WAKE_LSB 8
`define RCC_IE_WRITE_MASK 32'h0000_0707

// timing: prescaler reach, 2 to the 15 at code 1111
`define RCC_PRESCALE_BITS 15

`endif

// *** hdl/rcc_pkg.sv ***
// shared types of the rtc counter and compare core
package rcc_pkg;

  typedef logic [23:0] rcc_count_t;
  typedef logic [31:0] rcc_word_t;
  typedef logic [3:0] rcc_prescale_t;

  // event output waveform
  typedef enum logic [1:0] {
    RCC_WAVE_PULSE = 2'b01,
    RCC_WAVE_LEVEL = 2'b10
  } rcc_wave_t;

endpackage : rcc_pkg

// *** hdl/rcc_prescaler.sv ***
// power-of-two prescaler turning source clock ticks into second ticks
`timescale 1ns/1ns
`include "rcc_consts.svh"

module rcc_prescaler
  import rcc_pkg::*;
#(
  parameter int PRE_BITS = `RCC_PRESCALE_BITS
) (
  // clock and resets
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_soft_reset,
  // source tick and division code
  input wire logic i_src_tick,
  input wire rcc_prescale_t i_prescale_select,
  // divided tick, one cycle
  output logic o_second_tick
);

  logic [PRE_BITS-1:0] div_reg;
  logic [PRE_BITS-1:0] div_next;
  logic [PRE_BITS-1:0] mask;

  ////////////////////////////////////////////////////////////////////////////////
  // divider: a second tick on every 2^code source ticks
  always_comb begin
    mask = PRE_BITS'((32'h1 << i_prescale_select) - 32'h1);
    div_next = div_reg;
    if (i_src_tick) begin
      div_next = div_reg + {{(PRE_BITS-1){1'b0}}, 1'b1}; // free running
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || i_soft_reset) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // code 0 passes every tick; the low bits all ones ends one period
  assign o_second_tick = i_src_tick && ((div_reg & mask) == mask);

endmodule : rcc_prescaler

// *** hdl/rcc_core.sv ***
// rtc core: 24-bit counter, compare, status flags, event output pin, apb registers
`timescale 1ns/1ns
`include "rcc_consts.svh"

module rcc_core
  import rcc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and always-on domain resets
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_domain_soft_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // oscillator ticks, one cycle per source period
  input wire logic i_internal_osc_tick,
  input wire logic i_crystal_osc_tick,
  // oscillator controls
  output logic o_internal_osc_enable,
  output logic o_crystal_osc_enable,
  output logic o_crystal_startup_mode,
  // interrupt and wakeup requests
  output logic o_irq,
  output logic o_wake,
  // event output pin
  output logic o_event_out_pin,
  output logic o_event_out_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  rcc_count_t count_reg;
  rcc_count_t count_next;
  rcc_count_t compare_reg;
  rcc_count_t compare_next;
  rcc_word_t control_reg;
  rcc_word_t control_next;
  rcc_word_t enable_reg;
  rcc_word_t enable_next;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic level_flag_reg;
  logic level_flag_next;
  logic pulse_reg;
  logic pulse_next;
  logic run_prev_reg;
  logic run_prev_next;
  rcc_word_t rdata_reg;
  rcc_word_t rdata_next;
  logic [2:0] status_seen_reg;
  logic [2:0] status_seen_next;
  logic level_seen_reg;
  logic level_seen_next;

  logic dom_reset;
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic src_tick;
  logic second_tick;
  logic advance;
  rcc_count_t count_inc;
  logic match_evt;
  logic wrap_evt;
  logic out_evt;
  logic out_active;
  rcc_wave_t wave_mode;

  // true when the word address matches a register offset
  function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
    is_reg = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : is_reg

  ////////////////////////////////////////////////////////////////////////////////
  // reset and bus phases
  // only the always-on domain resets reach this state; no other system reset is wired in
  assign dom_reset = i_reset || i_domain_soft_reset;
  assign setup_phase = i_psel && !i_penable;
  assign access_phase = i_psel && i_penable;
  assign wr_en = access_phase && i_pwrite;
  assign rd_en = access_phase && !i_pwrite;
  assign addr_hit = is_reg(i_paddr, `RCC_OFS_ELAPSED_COUNT)
                 || is_reg(i_paddr, `RCC_OFS_ALARM_COMPARE)
                 || is_reg(i_paddr, `RCC_OFS_CLOCK_CONTROL)
                 || is_reg(i_paddr, `RCC_OFS_EVENT_STATUS)
                 || is_reg(i_paddr, `RCC_OFS_IRQ_WAKE_ENABLE);

  // zero wait state slave; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase && !addr_hit;
  assign o_prdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock source and prescaler
  // a disabled oscillator gives no ticks, so the counter stalls with it
  assign src_tick = control_reg[`RCC_CC_SOURCE_SELECT]
                  ? (i_crystal_osc_tick && control_reg[`RCC_CC_CRYSTAL_OSC_EN])
                  : (i_internal_osc_tick && control_reg[`RCC_CC_INTERNAL_OSC_EN]);

  rcc_prescaler #(
    .PRE_BITS(`RCC_PRESCALE_BITS)
  ) u_prescaler (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_soft_reset(i_domain_soft_reset),
    .i_src_tick(src_tick),
    .i_prescale_select(control_reg[`RCC_CC_PRESCALE_MSB:`RCC_CC_PRESCALE_LSB]),
    .o_second_tick(second_tick)
  );

  assign o_internal_osc_enable = control_reg[`RCC_CC_INTERNAL_OSC_EN];
  assign o_crystal_osc_enable = control_reg[`RCC_CC_CRYSTAL_OSC_EN];
  assign o_crystal_startup_mode = control_reg[`RCC_CC_CRYSTAL_STARTUP];

  ////////////////////////////////////////////////////////////////////////////////
  // counter events
  // the match is judged on the value the tick would produce, so a held count
  // does not raise the flag again on every system clock
  assign advance = second_tick && control_reg[`RCC_CC_RUN_ENABLE];
  assign count_inc = count_reg + 24'h000001;
  assign wrap_evt = advance && (count_reg == 24'hffffff);
  assign match_evt = advance && (count_inc == compare_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // counter next state
  always_comb begin
    count_next = count_reg;
    run_prev_next = control_reg[`RCC_CC_RUN_ENABLE];
    if (control_reg[`RCC_CC_RUN_ENABLE] && !run_prev_reg) begin
      count_next = '0;
    end else if (match_evt && control_reg[`RCC_CC_CLEAR_ON_MATCH]) begin
      count_next = '0;
    end else if (advance) begin
      count_next = count_inc;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (dom_reset) begin
      count_reg <= '0;
      run_prev_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      run_prev_reg <= run_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writable registers next state
  always_comb begin
    compare_next = compare_reg;
    control_next = control_reg;
    enable_next = enable_reg;
    if (wr_en && is_reg(i_paddr, `RCC_OFS_ALARM_COMPARE)) begin
      compare_next = i_pwdata[23:0];
    end
    if (wr_en && is_reg(i_paddr, `RCC_OFS_CLOCK_CONTROL)) begin
      control_next = i_pwdata & `RCC_CC_WRITE_MASK;
    end
    if (wr_en && is_reg(i_paddr, `RCC_OFS_IRQ_WAKE_ENABLE)) begin
      enable_next = i_pwdata & `RCC_IE_WRITE_MASK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (dom_reset) begin
      compare_reg <= 24'(`RCC_RST_ALARM_COMPARE);
      control_reg <= `RCC_RST_CLOCK_CONTROL;
      enable_reg <= `RCC_RST_IRQ_WAKE_ENABLE;
    end else begin
      compare_reg <= compare_next;
      control_reg <= control_next;
      enable_reg <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags: sticky, cleared by a read of the status register
  // only bits captured at the setup phase are cleared, so a flag raised between
  // setup and access survives; a set in the clearing cycle also wins
  always_comb begin
    status_next = status_reg;
    if (rd_en && is_reg(i_paddr, `RCC_OFS_EVENT_STATUS)) begin
      status_next = status_reg & ~status_seen_reg;
    end
    if (second_tick) begin
      status_next[`RCC_ST_SECOND] = 1'b1;
    end
    if (match_evt) begin
      status_next[`RCC_ST_MATCH] = 1'b1;
    end
    if (wrap_evt) begin
      status_next[`RCC_ST_OVERFLOW] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (dom_reset) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // requests follow the sticky flags, gated by their enables
  assign o_irq = |(status_reg & enable_reg[2:0]);
  assign o_wake = |(status_reg & enable_reg[`RCC_IE_WAKE_LSB+2:`RCC_IE_WAKE_LSB]);

  ////////////////////////////////////////////////////////////////////////////////
  // event output pin
  assign wave_mode = control_reg[`RCC_CC_OUT_WAVE_MODE] ? RCC_WAVE_LEVEL : RCC_WAVE_PULSE;
  assign out_evt = control_reg[`RCC_CC_OUT_EVENT_SELECT] ? second_tick : match_evt;

  // pulse ends on the next source tick, one source period long; level flag
  // keeps the pin active until software reads clock_control
  always_comb begin
    pulse_next = pulse_reg;
    level_flag_next = level_flag_reg;
    case (wave_mode)
      RCC_WAVE_PULSE: begin
        if (out_evt) begin
          pulse_next = 1'b1;
        end else if (src_tick) begin
          pulse_next = 1'b0;
        end
      end
      RCC_WAVE_LEVEL: begin
        pulse_next = 1'b0;
      end
      default: begin
        pulse_next = 1'b0;
      end
    endcase
    if (rd_en && is_reg(i_paddr, `RCC_OFS_CLOCK_CONTROL) && level_seen_reg) begin
      level_flag_next = 1'b0;
    end
    if (out_evt && (wave_mode == RCC_WAVE_LEVEL)) begin
      level_flag_next = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (dom_reset) begin
      pulse_reg <= 1'b0;
      level_flag_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
      level_flag_reg <= level_flag_next;
    end
  end

  assign out_active = (wave_mode == RCC_WAVE_LEVEL) ? level_flag_reg : pulse_reg;
  assign o_event_out_pin = out_active ^ control_reg[`RCC_CC_OUT_POLARITY];
  assign o_event_out_oe = control_reg[`RCC_CC_OUT_PIN_ENABLE];

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase and shown in the access phase
  always_comb begin
    rdata_next = rdata_reg;
    status_seen_next = status_seen_reg;
    level_seen_next = level_seen_reg;
    if (setup_phase && !i_pwrite) begin
      rdata_next = '0;
      status_seen_next = '0;
      level_seen_next = 1'b0;
      if (is_reg(i_paddr, `RCC_OFS_ELAPSED_COUNT)) begin
        rdata_next = {8'h00, count_reg};
      end else if (is_reg(i_paddr, `RCC_OFS_ALARM_COMPARE)) begin
        rdata_next = {8'h00, compare_reg};
      end else if (is_reg(i_paddr, `RCC_OFS_CLOCK_CONTROL)) begin
        rdata_next = control_reg;
        rdata_next[`RCC_CC_OUT_LEVEL_FLAG] = level_flag_reg;
        level_seen_next = level_flag_reg;
      end else if (is_reg(i_paddr, `RCC_OFS_EVENT_STATUS)) begin
        rdata_next = {29'h0, status_reg};
        status_seen_next = status_reg;
      end else if (is_reg(i_paddr, `RCC_OFS_IRQ_WAKE_ENABLE)) begin
        rdata_next = enable_reg;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (dom_reset) begin
      rdata_reg <= '0;
      status_seen_reg <= '0;
      level_seen_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      status_seen_reg <= status_seen_next;
      level_seen_reg <= level_seen_next;
    end
  end

endmodule : rcc_core

// *** verif/rcc_core_monitor.sv ***
// port checker for the rtc core, bound onto every rcc_core
`timescale 1ns/1ns
module rcc_monitor #(
  parameter int ADDR_W = 12
) (
  // clock and domain resets
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_domain_soft_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // interrupt and event pin
  input wire logic o_irq,
  input wire logic o_event_out_pin,
  input wire logic o_event_out_oe
);
  logic rst;
  logic acc;
  logic [9:0] wa;
  logic [3:0] oc_reg, oc_next;
  logic [2:0] ie_reg, ie_next;
  // word index: the core ignores the byte bits
  assign rst = i_reset | i_domain_soft_reset;
  assign acc = i_psel & i_penable;
  assign wa = i_paddr[11:2];
  // shadow of pin bits 19:16 and irq enables, so pin rules know the mode
  always_comb begin
    oc_next = (acc && i_pwrite && wa == 10'h002) ? i_pwdata[19:16] : oc_reg;
    ie_next = (acc && i_pwrite && wa == 10'h004) ? i_pwdata[2:0] : ie_reg;
  end
  always_ff @(posedge i_sys_clk) begin
    oc_reg <= rst ? 4'h0 : oc_next;
    ie_reg <= rst ? 3'h0 : ie_next;
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (rst);
  AST_RESET_IDLE: assert property ($fell(i_reset)
    |-> !o_event_out_oe && !o_irq && o_prdata == 32'h0)
    else $error("outputs not idle after reset");
  AST_UNMAPPED: assert property (acc && wa > 10'h004
    |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_OE_FOLLOWS: assert property (acc && i_pwrite && wa == 10'h002
    |=> o_event_out_oe == $past(i_pwdata[16]))
    else $error("pin enable does not follow control write");
  AST_COUNT_RSVD: assert property (acc && !i_pwrite && wa == 10'h000
    |-> o_prdata[31:24] == 8'h00)
    else $error("count read shows reserved bits");
  AST_CTL_RSVD: assert property (acc && !i_pwrite && wa == 10'h002
    |-> (o_prdata & 32'hffe0f0c0) == 32'h0)
    else $error("control read shows reserved bits");
  AST_PULSE_END: assert property (!oc_reg[2] && o_event_out_oe
    && o_event_out_pin != oc_reg[3]
    |-> ##[1:8] o_event_out_pin == oc_reg[3])
    else $error("pulse outlasts one source period");
  AST_LEVEL_HOLD: assert property (oc_reg[2] && o_event_out_pin != oc_reg[3]
    && !(acc && wa == 10'h002)
    |=> o_event_out_pin != oc_reg[3])
    else $error("level output dropped without a flag read");
  AST_IRQ_MASKED: assert property (ie_reg == 3'h0 |-> !o_irq)
    else $error("irq raised with all enables clear");
  // main scenarios reached
  cover property (o_pslverr);
  cover property (oc_reg[2] && o_event_out_pin != oc_reg[3]);
  cover property ($rose(o_irq));
endmodule : rcc_monitor

bind rcc_core rcc_monitor #(.ADDR_W(ADDR_W)) i_rcc_monitor (
  .i_sys_clk, .i_reset, .i_domain_soft_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pslverr, .o_irq, .o_event_out_pin, .o_event_out_oe
);

// *** verif/rcc_core_tb_top.sv ***
// self-checking bench for the rtc core: apb accesses and oscillator ticks
`timescale 1ns/1ns
module rcc_core_tb_top;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_domain_soft_reset = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_internal_osc_tick = 1'b0, i_crystal_osc_tick = 1'b0;
  logic [31:0] o_prdata;
  logic o_pslverr, o_irq, o_wake, o_event_out_pin, o_event_out_oe;
  logic o_pready, o_internal_osc_enable, o_crystal_osc_enable, o_crystal_startup_mode;
  logic serr;
  logic [1:0] ph = 2'h0;
  logic [31:0] hi;
  int errors = 0;
  int check_count = 0;
  rcc_core i_rcc_core (
    .i_sys_clk, .i_reset, .i_domain_soft_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_internal_osc_tick, .i_crystal_osc_tick,
    .o_internal_osc_enable, .o_crystal_osc_enable, .o_crystal_startup_mode, .o_irq,
    .o_wake, .o_event_out_pin, .o_event_out_oe
  );
  // 100 mhz system clock
  always #5 i_sys_clk = ~i_sys_clk;
  // internal oscillator runs free, one tick every fourth cycle
  always @(posedge i_sys_clk) begin
    #1;
    ph = ph + 2'h1;
    i_internal_osc_tick = (ph == 2'h3);
  end
  //////////////////////////////////////////////////////////////////////////
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : cb
  // apb write: setup, access, then one idle cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_psel = 1'b1;
    i_pwrite = 1'b1;
    i_paddr = a;
    i_pwdata = d;
    cyc(1);
    i_penable = 1'b1;
    cyc(1);
    i_psel = 1'b0;
    i_penable = 1'b0;
    cyc(1);
  endtask : wr
  // apb read and compare; data and error taken at the access edge
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    i_psel = 1'b1;
    i_pwrite = 1'b0;
    i_paddr = a;
    cyc(1);
    i_penable = 1'b1;
    @(posedge i_sys_clk);
    chk(n, e, o_prdata);
    serr = o_pslverr;
    #1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    cyc(1);
  endtask : rc
  // crystal ticks on demand, so counts are exact
  task automatic xt(input int n);
    repeat (n) begin
      i_crystal_osc_tick = 1'b1;
      cyc(1);
      i_crystal_osc_tick = 1'b0;
      cyc(2);
    end
  endtask : xt
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // watchdog, some thirty times the expected run
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    i_reset = 1'b0;
    cyc(1);
    // reset values, unmapped word, read-only count
    rc("count", 12'h000, 32'h0);
    rc("compare", 12'h004, 32'h0);
    rc("control", 12'h008, 32'h00000f04);
    rc("status", 12'h00c, 32'h0);
    rc("enables", 12'h010, 32'h0);
    cb("pready", 1'b1, o_pready);
    cb("internal en", 1'b1, o_internal_osc_enable);
    cb("crystal en", 1'b0, o_crystal_osc_enable);
    cb("startup", 1'b0, o_crystal_startup_mode);
    rc("unmapped", 12'h014, 32'h0);
    cb("slverr", 1'b1, serr);
    wr(12'h000, 32'h00ffffff);
    rc("count", 12'h000, 32'h0);
    $display("test reset done");
    // reserved bits and the read-clear flag ignore writes
    wr(12'h004, 32'hffffffff);
    rc("compare", 12'h004, 32'h00ffffff);
    wr(12'h010, 32'hffffffff);
    rc("enables", 12'h010, 32'h00000707);
    wr(12'h008, 32'hfff0f0c0);
    rc("control", 12'h008, 32'h0);
    $display("test masks done");
    // crystal source; free internal ticks must not count
    wr(12'h008, 32'h0000002f);
    cb("crystal en", 1'b1, o_crystal_osc_enable);
    cb("startup", 1'b1, o_crystal_startup_mode);
    xt(5);
    rc("count", 12'h000, 32'h5);
    wr(12'h008, 32'h0000000e);
    xt(3);
    rc("held", 12'h000, 32'h5);
    wr(12'h008, 32'h0000000f);
    rc("restart", 12'h000, 32'h0);
    wr(12'h008, 32'h0000020f);
    xt(8);
    rc("div4", 12'h000, 32'h2);
    $display("test count done");
    // match without clear keeps counting
    wr(12'h008, 32'h0000000e);
    wr(12'h004, 32'h3);
    wr(12'h010, 32'h00000202);
    rc("status", 12'h00c, 32'h1);
    wr(12'h008, 32'h0000000f);
    xt(5);
    rc("count", 12'h000, 32'h5);
    cb("irq", 1'b1, o_irq);
    cb("wake", 1'b1, o_wake);
    rc("status", 12'h00c, 32'h3);
    rc("status", 12'h00c, 32'h0);
    cb("irq", 1'b0, o_irq);
    // match with clear restarts from zero
    wr(12'h004, 32'h7);
    wr(12'h008, 32'h0000001f);
    xt(2);
    rc("cleared", 12'h000, 32'h0);
    rc("status", 12'h00c, 32'h3);
    xt(3);
    rc("resumed", 12'h000, 32'h3);
    $display("test match done");
    // level mode, active low, held until the flag is read
    wr(12'h008, 32'h000d001f);
    cb("idle pin", 1'b1, o_event_out_pin);
    cb("pin oe", 1'b1, o_event_out_oe);
    xt(4);
    cyc(20);
    cb("held pin", 1'b0, o_event_out_pin);
    rc("flag", 12'h008, 32'h001d001f);
    cb("released", 1'b1, o_event_out_pin);
    $display("test level done");
    // second events at code 1: 4 of every 8 cycles active
    wr(12'h008, 32'h00030105);
    cyc(16);
    hi = 32'h0;
    repeat (32) begin
      cyc(1);
      hi = hi + {31'h0, o_event_out_pin};
    end
    chk("pulse", 32'h10, hi);
    wr(12'h008, 32'h00000004);
    cb("pin oe", 1'b0, o_event_out_oe);
    $display("test pulse done");
    // domain software reset restores the registers
    wr(12'h004, 32'h5);
    i_domain_soft_reset = 1'b1;
    cyc(2);
    i_domain_soft_reset = 1'b0;
    cyc(1);
    rc("control", 12'h008, 32'h00000f04);
    rc("compare", 12'h004, 32'h0);
    $display("test soft reset done");
    print_verdict();
  end
endmodule : rcc_core_tb_top
